/* src/lpd_instr_map.vh */
// lpd_instr_map.vh - instruction codes, field positions and reset values
// assumes: included by the instruction decoder
`ifndef LPD_INSTR_MAP_VH
`define LPD_INSTR_MAP_VH

// instruction class bits (highest set bit among db7..db2)
`define LPD_BIT_DRIVER      2
`define LPD_BIT_POWER       3
`define LPD_BIT_CONTRAST    4
`define LPD_BIT_ENTRY       5
// fixed opcodes
`define LPD_OP_START_OSC    8'h03
`define LPD_OP_CLEAR        8'h01
// field positions
`define LPD_POS_SGS         0
`define LPD_POS_CMS         1
`define LPD_POS_STB         0
`define LPD_POS_SLP         1
`define LPD_POS_AMP         2
`define LPD_POS_GR          0
`define LPD_POS_ID          1
`define LPD_POS_ROM         2
`define LPD_POS_SW          2
// reset values
`define LPD_RST_CONTRAST    5'h00
`define LPD_RST_BOOST       2'h0
`define LPD_RST_BIAS        3'h0
`define LPD_RST_ADDR_INC    1'b1
// forbidden codes
`define LPD_BOOST_BAD       2'h3
`define LPD_BIAS_BAD_MIN    3'h6
// oscillator settle wait for the host, in microseconds
`define LPD_OSC_SETTLE_US   10000

`endif

/* src/lpd_pin_sync.v */
// lpd_pin_sync.v - three-stage synchroniser for host pins
// assumes: pins are asynchronous to core_clk
`timescale 1ns/1ps

module lpd_pin_sync (
    // clock and reset
    input  wire        core_clk,
    input  wire        reset,
    // pins in, synchronised out
    input  wire [9:0]  pinIn,
    output reg  [9:0]  pinOut
);

    reg [9:0] stage1Ff;
    reg [9:0] stage2Ff;
    reg [9:0] stage3Ff;

    // first stage feeds only the second; accept when stages 2 and 3 agree
    always @(posedge core_clk) begin
        if (reset) begin
            stage1Ff <= 10'h000;
            stage2Ff <= 10'h000;
            stage3Ff <= 10'h000;
            pinOut   <= 10'h000;
        end else begin
            stage1Ff <= pinIn;
            stage2Ff <= stage1Ff;
            stage3Ff <= stage2Ff;
            pinOut   <= (stage2Ff & stage3Ff) | (pinOut & (stage2Ff | stage3Ff));
        end
    end

endmodule // lpd_pin_sync

/* src/lpd_contrast_lut.v */
// lpd_contrast_lut.v - contrast, booster and bias code translation
// assumes: codes come from the decoder's held settings
`timescale 1ns/1ps

module lpd_contrast_lut (
    // settings in
    input  wire [4:0]  contrastCode,
    input  wire [1:0]  boosterSelect,
    input  wire [2:0]  biasSelect,
    // translated values
    output reg  [5:0]  resistorTenths,
    output reg  [1:0]  boostFactor,
    output reg  [3:0]  biasHalfDenom,
    output reg         codeInhibited
);

    // resistor in tenths of r: 32 at code 0 down to 1 at code 31
    always @* begin
        resistorTenths = 6'h20 - {1'b0, contrastCode};
        boostFactor    = 2'h1;
        biasHalfDenom  = 4'hd;
        codeInhibited  = 1'b0;
        // booster: 1x, 2x, 3x; 11 forbidden
        case (boosterSelect)
            2'h0:    boostFactor = 2'h1;
            2'h1:    boostFactor = 2'h2;
            2'h2:    boostFactor = 2'h3;
            default: begin
                boostFactor   = 2'h1;
                codeInhibited = 1'b1;
            end
        endcase
        // bias as twice the denominator: 13,12,11,10,9,8
        case (biasSelect)
            3'h0:    biasHalfDenom = 4'hd;
            3'h1:    biasHalfDenom = 4'hc;
            3'h2:    biasHalfDenom = 4'hb;
            3'h3:    biasHalfDenom = 4'ha;
            3'h4:    biasHalfDenom = 4'h9;
            3'h5:    biasHalfDenom = 4'h8;
            default: begin
                biasHalfDenom = 4'hd;
                codeInhibited = 1'b1;
            end
        endcase
    end

endmodule // lpd_contrast_lut

/* src/lpd_instr_decode.v */
// lpd_instr_decode.v - power, drive and entry mode instruction decoder
// assumes: host drives register select, read/write, write strobe and db
// pins asynchronously; the oscillator gate is outside this block.
`timescale 1ns/1ps
`include "lpd_instr_map.vh"

module lpd_instr_decode (
    // clock and reset
    input  wire        core_clk,
    input  wire        reset,
    // host pins
    input  wire        register_select,
    input  wire        readNotWrite,
    input  wire        writeStrobe,
    input  wire [7:0]  dataBus,
    // events from neighbouring blocks
    input  wire        keyPressed,
    input  wire        keyscanIrqEnable,
    input  wire        clearBusy,
    // driver shift outputs
    output reg         common_shift_dir,
    output reg         segment_shift_dir,
    // power outputs
    output reg         amplifier_enable,
    output reg         sleep_request,
    output reg         standby_request,
    output reg         oscRun,
    output reg         oscRestartPulse,
    output reg         keyscanRun,
    output reg         displayRun,
    output reg         keyscanIrq,
    // contrast outputs
    output reg  [4:0]  contrast_code,
    output reg  [1:0]  booster_select,
    output reg  [2:0]  bias_select,
    output wire [5:0]  resistorTenths,
    output wire [1:0]  boostFactor,
    output wire [3:0]  biasHalfDenom,
    output wire        codeInhibited,
    // entry mode outputs
    output reg         fontBank,
    output reg         addrIncrement,
    output reg         graphics_mode,
    output reg         cursorMovesRight,
    // status
    output reg         instrAccepted,
    output reg         instrRejected
);

    // ----------------------------------------------------------------
    // instruction classes
    // ----------------------------------------------------------------
    localparam [4:0] CLS_NONE     = 5'h01;
    localparam [4:0] CLS_DRIVER   = 5'h02;
    localparam [4:0] CLS_POWER    = 5'h04;
    localparam [4:0] CLS_CONTRAST = 5'h08;
    localparam [4:0] CLS_ENTRY    = 5'h10;

    // settle time in cycles, for reference by host-side checking
    localparam integer CLK_MHZ        = 200;
    localparam integer OSC_SETTLE_CYC = `LPD_OSC_SETTLE_US * CLK_MHZ;

    // highest set bit among db7..db2 picks the class
    function [4:0] classOf;
        input [7:0] code;
        begin
            if (code[7:6] != 2'h0)
                classOf = CLS_NONE;
            else if (code[`LPD_BIT_ENTRY])
                classOf = CLS_ENTRY;
            else if (code[`LPD_BIT_CONTRAST])
                classOf = CLS_CONTRAST;
            else if (code[`LPD_BIT_POWER])
                classOf = CLS_POWER;
            else if (code[`LPD_BIT_DRIVER])
                classOf = CLS_DRIVER;
            else
                classOf = CLS_NONE;
        end
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisation
    // ----------------------------------------------------------------
    wire [9:0] syncPins;
    reg        strobeDlyFf;
    reg        rwStage1Ff;
    reg        rwStage2Ff;
    reg        rwStage3Ff;
    reg        rwSyncFf;

    lpd_pin_sync u_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .pinIn    ({writeStrobe, register_select, dataBus}),
        .pinOut   (syncPins)
    );

    wire       strobeSync = syncPins[9];
    wire       rsSync     = syncPins[8];
    wire [7:0] dbSync     = syncPins[7:0];

    // rising edge of the filtered write strobe
    always @(posedge core_clk) begin
        if (reset)
            strobeDlyFf <= 1'b0;
        else
            strobeDlyFf <= strobeSync;
    end

    // read/write pin: own three stages, same agreement rule and depth
    // as the shared synchroniser, so it lines up with strobe and data
    always @(posedge core_clk) begin
        if (reset) begin
            rwStage1Ff <= 1'b1;
            rwStage2Ff <= 1'b1;
            rwStage3Ff <= 1'b1;
            rwSyncFf   <= 1'b1;
        end else begin
            rwStage1Ff <= readNotWrite;
            rwStage2Ff <= rwStage1Ff;
            rwStage3Ff <= rwStage2Ff;
            rwSyncFf   <= (rwStage2Ff & rwStage3Ff) | (rwSyncFf & (rwStage2Ff | rwStage3Ff));
        end
    end

    wire instrWrite = strobeSync & ~strobeDlyFf & ~rsSync & ~rwSyncFf;

    // ----------------------------------------------------------------
    // decode and mode gating
    // ----------------------------------------------------------------
    reg  [4:0] cls;
    reg        isStartOsc;
    reg        allowed;
    // layout chosen by the first contrast half; it steers the second half
    reg        layoutSelFf;

    // mode gating per instruction class
    always @* begin
        cls        = classOf(dbSync);
        isStartOsc = (dbSync == `LPD_OP_START_OSC);
        allowed    = 1'b1;
        if (standby_request) begin
            allowed = (cls == CLS_POWER) | isStartOsc;
        end else if (sleep_request) begin
            allowed = (cls == CLS_POWER);
        end
        // clear display owns the register until it finishes
        if (clearBusy)
            allowed = 1'b0;
    end

    wire exec = instrWrite & allowed;

    // ----------------------------------------------------------------
    // held settings
    // ----------------------------------------------------------------
    // all but the power settings frozen in sleep by gating
    always @(posedge core_clk) begin
        if (reset) begin
            common_shift_dir  <= 1'b0;
            segment_shift_dir <= 1'b0;
            amplifier_enable  <= 1'b0;
            sleep_request     <= 1'b0;
            standby_request   <= 1'b0;
            contrast_code     <= `LPD_RST_CONTRAST;
            booster_select    <= `LPD_RST_BOOST;
            bias_select       <= `LPD_RST_BIAS;
            fontBank          <= 1'b0;
            addrIncrement     <= `LPD_RST_ADDR_INC;
            graphics_mode     <= 1'b0;
            layoutSelFf       <= 1'b0;
        end else if (exec) begin
            case (cls)
                CLS_DRIVER: begin
                    common_shift_dir  <= dbSync[`LPD_POS_CMS];
                    segment_shift_dir <= dbSync[`LPD_POS_SGS];
                end
                CLS_POWER: begin
                    if (standby_request) begin
                        // only amp and standby cancel count in standby
                        amplifier_enable <= dbSync[`LPD_POS_AMP];
                        standby_request  <= dbSync[`LPD_POS_STB];
                    end else begin
                        amplifier_enable <= dbSync[`LPD_POS_AMP];
                        sleep_request    <= dbSync[`LPD_POS_SLP];
                        standby_request  <= dbSync[`LPD_POS_STB];
                    end
                end
                CLS_CONTRAST: begin
                    if (dbSync[3] == 1'b0) begin
                        // layout select, held for the second half
                        layoutSelFf <= dbSync[`LPD_POS_SW];
                        if (dbSync[`LPD_POS_SW] == 1'b0) begin
                            contrast_code[4:3] <= dbSync[1:0];
                        end else begin
                            booster_select <= dbSync[1:0];
                        end
                    end else if (layoutSelFf == 1'b0) begin
                        contrast_code[2:0] <= dbSync[2:0];
                    end else begin
                        bias_select <= dbSync[2:0];
                    end
                end
                CLS_ENTRY: begin
                    fontBank      <= dbSync[`LPD_POS_ROM];
                    addrIncrement <= dbSync[`LPD_POS_ID];
                    graphics_mode <= dbSync[`LPD_POS_GR];
                end
                default: begin
                    fontBank <= fontBank;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // second-half contrast fields
    // ----------------------------------------------------------------
    // db3 set inside the contrast class carries the lower half; whether it
    // lands in the contrast code or the bias field depends on the layout
    // bit of the last accepted first half, so a host that skips the first
    // half after reset writes the contrast code, never the bias.
    // both halves are handled in the held settings process above, which
    // keeps a single driver on every setting.

    // ----------------------------------------------------------------
    // power state outputs
    // ----------------------------------------------------------------
    // oscillator runs unless standby halts it; restart on start command
    always @(posedge core_clk) begin
        if (reset) begin
            oscRun          <= 1'b1;
            oscRestartPulse <= 1'b0;
            keyscanRun      <= 1'b1;
            displayRun      <= 1'b1;
        end else begin
            oscRestartPulse <= exec & isStartOsc & standby_request;
            if (exec && isStartOsc)
                oscRun <= 1'b1;
            // standby entry halts oscillator; a restart then holds
            else if (exec && cls == CLS_POWER && dbSync[`LPD_POS_STB] && !standby_request)
                oscRun <= 1'b0;
            else if (!standby_request)
                oscRun <= 1'b1;
            keyscanRun <= ~standby_request;
            displayRun <= ~standby_request & ~sleep_request;
        end
    end

    // wake-up interrupt; set wins, cleared when standby is left
    always @(posedge core_clk) begin
        if (reset)
            keyscanIrq <= 1'b0;
        else if (standby_request && keyscanIrqEnable && keyPressed)
            keyscanIrq <= 1'b1;
        else if (!standby_request)
            keyscanIrq <= 1'b0;
    end

    always @(posedge core_clk) begin
        if (reset)
            cursorMovesRight <= `LPD_RST_ADDR_INC;
        else if (exec && cls == CLS_ENTRY)
            cursorMovesRight <= dbSync[`LPD_POS_ID];
    end

    // status pulses for the host-side observer
    always @(posedge core_clk) begin
        if (reset) begin
            instrAccepted <= 1'b0;
            instrRejected <= 1'b0;
        end else begin
            instrAccepted <= exec;
            instrRejected <= instrWrite & ~allowed;
        end
    end

    // contrast, booster and bias codes are translated for the outputs
    lpd_contrast_lut u_lut (
        .contrastCode   (contrast_code),
        .boosterSelect  (booster_select),
        .biasSelect     (bias_select),
        .resistorTenths (resistorTenths),
        .boostFactor    (boostFactor),
        .biasHalfDenom  (biasHalfDenom),
        .codeInhibited  (codeInhibited)
    );

endmodule // lpd_instr_decode

/* tb/lpd_instr_decode_props.sv */
// lpd_instr_decode_props.sv - port assertions for the decoder
// assumes: bound to lpd_instr_decode, one clock, sync reset
`timescale 1ns/1ps

module lpd_instr_decode_props (
    // clock and reset
    input wire       core_clk,
    input wire       reset,
    // side inputs
    input wire       keyPressed,
    input wire       keyscanIrqEnable,
    // settings
    input wire       common_shift_dir,
    input wire       segment_shift_dir,
    input wire       amplifier_enable,
    input wire       sleep_request,
    input wire       standby_request,
    input wire [4:0] contrast_code,
    input wire [1:0] booster_select,
    input wire [2:0] bias_select,
    input wire       fontBank,
    input wire       addrIncrement,
    input wire       graphics_mode,
    input wire       cursorMovesRight,
    // run flags and events
    input wire       oscRun,
    input wire       oscRestartPulse,
    input wire       keyscanRun,
    input wire       displayRun,
    input wire       keyscanIrq,
    input wire       instrAccepted,
    input wire       instrRejected,
    // translated codes
    input wire [5:0] resistorTenths,
    input wire [1:0] boostFactor,
    input wire [3:0] biasHalfDenom,
    input wire       codeInhibited
);
    // ---------------------------------------------------------------
    // one domain, so clock and reset are given once
    // ---------------------------------------------------------------
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (reset);

    property p_standby_halt;
        standby_request && $past(standby_request) |-> !keyscanRun && !displayRun;
    endproperty
    a_standby_halt: assert property (p_standby_halt) else $error("standby still running");
    property p_sleep_run;
        sleep_request && $past(sleep_request) && !standby_request |-> oscRun && keyscanRun && !displayRun;
    endproperty
    a_sleep_run: assert property (p_sleep_run) else $error("sleep run flags wrong");
    property p_wake_irq;
        standby_request && keyPressed && keyscanIrqEnable |=> keyscanIrq;
    endproperty
    a_wake_irq: assert property (p_wake_irq) else $error("no wake interrupt");
    property p_irq_clear;
        $fell(standby_request) |-> ##[0:1] !keyscanIrq;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("interrupt outlived standby");
    property p_contrast_step;
        resistorTenths == 6'h20 - {1'b0, contrast_code};
    endproperty
    a_contrast_step: assert property (p_contrast_step) else $error("contrast step wrong");
    property p_boost_map;
        booster_select != 2'h3 |-> boostFactor == booster_select + 2'h1;
    endproperty
    a_boost_map: assert property (p_boost_map) else $error("boost factor wrong");
    property p_bias_map;
        bias_select < 3'h6 && booster_select != 2'h3 |-> biasHalfDenom == 4'hd - {1'b0, bias_select} && !codeInhibited;
    endproperty
    a_bias_map: assert property (p_bias_map) else $error("bias value wrong");
    property p_cursor;
        cursorMovesRight == addrIncrement;
    endproperty
    a_cursor: assert property (p_cursor) else $error("cursor direction wrong");
    property p_pulse;
        instrAccepted |-> !instrRejected ##1 !instrAccepted;
    endproperty
    a_pulse: assert property (p_pulse) else $error("answer pulse malformed");
    property p_hold;
        !$stable({common_shift_dir, segment_shift_dir, amplifier_enable, sleep_request, standby_request,
                  booster_select, bias_select, fontBank, addrIncrement, graphics_mode})
            |-> instrAccepted || $past(instrAccepted);
    endproperty
    a_hold: assert property (p_hold) else $error("setting moved without write");
    property p_osc_pulse;
        oscRestartPulse |=> oscRun && !oscRestartPulse;
    endproperty
    a_osc_pulse: assert property (p_osc_pulse) else $error("oscillator not restarted");
endmodule // lpd_instr_decode_props

bind lpd_instr_decode lpd_instr_decode_props lpd_instr_decode_props_i (
    .core_clk, .reset, .keyPressed, .keyscanIrqEnable, .common_shift_dir, .segment_shift_dir,
    .amplifier_enable, .sleep_request, .standby_request, .contrast_code, .booster_select, .bias_select,
    .fontBank, .addrIncrement, .graphics_mode, .cursorMovesRight, .oscRun, .oscRestartPulse, .keyscanRun,
    .displayRun, .keyscanIrq, .instrAccepted, .instrRejected, .resistorTenths, .boostFactor,
    .biasHalfDenom, .codeInhibited);

/* tb/lpd_host_model.sv */
// lpd_host_model.sv - host side writing instruction bytes
// assumes: put() is called from one process at a time
`timescale 1ns/1ps

module lpd_host_model #(
    parameter SETTLE_CYC = 20
) (
    // clock
    input  wire        core_clk,
    // host pins
    output logic       register_select,
    output logic       readNotWrite,
    output logic       writeStrobe,
    output logic [7:0] dataBus
);
    // idle with read selected, so no write can be taken
    initial begin
        register_select = 1'b1;
        readNotWrite    = 1'b1;
        writeStrobe     = 1'b0;
        dataBus         = 8'h00;
    end

    // settle wait (shortened, 10 ms is too long to simulate)
    task put(input logic [7:0] code);
        @(negedge core_clk);
        register_select = 1'b0;
        readNotWrite    = 1'b0;
        dataBus         = code;
        @(negedge core_clk);
        writeStrobe = 1'b1;
        repeat (4) @(negedge core_clk);
        writeStrobe = 1'b0;
        repeat (4) @(negedge core_clk);
        // released bus never keeps showing the old byte
        dataBus         = ~code;
        register_select = 1'b1;
        readNotWrite    = 1'b1;
        if (code == 8'h03)
            repeat (SETTLE_CYC) @(negedge core_clk);
    endtask
endmodule // lpd_host_model

/* tb/lpd_testbench.sv */
// lpd_testbench.sv - self-checking bench for the instruction decoder
// assumes: host model drives pins, bench drives key and busy inputs
`timescale 1ns/1ps

module testbench;
    // clock, reset and side inputs
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        keyPressed = 1'b0;
    logic        keyscanIrqEnable = 1'b0;
    logic        clearBusy = 1'b0;
    // design pins
    wire         register_select, readNotWrite, writeStrobe;
    wire  [7:0]  dataBus;
    wire         common_shift_dir, segment_shift_dir, amplifier_enable, sleep_request, standby_request;
    wire         oscRun, oscRestartPulse, keyscanRun, displayRun, keyscanIrq, instrAccepted, instrRejected;
    wire         fontBank, addrIncrement, graphics_mode, cursorMovesRight, codeInhibited;
    wire  [4:0]  contrast_code;
    wire  [1:0]  booster_select, boostFactor;
    wire  [2:0]  bias_select;
    wire  [5:0]  resistorTenths;
    wire  [3:0]  biasHalfDenom;
    // reference state and bookkeeping
    logic        eCms = 0, eSgs = 0, eAmp = 0, eSlp = 0, eStb = 0, eOsc = 1, eRom = 0, eId = 1, eGr = 0;
    logic [1:0]  eBt = 2'h0;
    logic [2:0]  eBs = 3'h0;
    logic        eSw = 1'b0;
    logic [4:0]  eCt = 5'h00;
    logic        okSeen;
    logic [31:0] r;
    logic [35:0] noteQ[$];
    int          num_errors = 0;
    int          n_tests = 0;
    int          seed = 2301;
    wire  [35:0] seenVec = {instrAccepted, common_shift_dir, segment_shift_dir, amplifier_enable,
                            sleep_request, standby_request, oscRun, keyscanRun, displayRun, contrast_code,
                            booster_select, bias_select, fontBank, addrIncrement, graphics_mode,
                            cursorMovesRight, resistorTenths, boostFactor, biasHalfDenom, codeInhibited};

    always #2.5 core_clk = ~core_clk;

    lpd_host_model #(.SETTLE_CYC(20)) lpd_host_model_i (.core_clk, .register_select, .readNotWrite,
        .writeStrobe, .dataBus);
    lpd_instr_decode lpd_instr_decode_i (.core_clk, .reset, .register_select, .readNotWrite, .writeStrobe,
        .dataBus, .keyPressed, .keyscanIrqEnable, .clearBusy, .common_shift_dir, .segment_shift_dir,
        .amplifier_enable, .sleep_request, .standby_request, .oscRun, .oscRestartPulse, .keyscanRun,
        .displayRun, .keyscanIrq, .contrast_code, .booster_select, .bias_select, .resistorTenths,
        .boostFactor, .biasHalfDenom, .codeInhibited, .fontBank, .addrIncrement, .graphics_mode,
        .cursorMovesRight, .instrAccepted, .instrRejected);

    // ---------------------------------------------------------------
    // checking and verdict
    // ---------------------------------------------------------------
    task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task print_verdict;
        if (num_errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // expected port picture from the reference state
    function automatic logic [35:0] expVec(input logic ok);
        expVec = {ok, eCms, eSgs, eAmp, eSlp, eStb, eStb ? eOsc : 1'b1, !eStb, !eStb && !eSlp, eCt,
                  eBt, eBs, eRom, eId, eGr, eId, 6'h20 - {1'b0, eCt}, eBt + 2'h1, 4'hd - {1'b0, eBs}, 1'b0};
    endfunction

    // update reference, note the answer, then write the byte
    task automatic send(input logic [7:0] c);
        logic ok;
        ok = !clearBusy && (eStb ? (c[7:3] == 5'h01 || c == 8'h03) : (!eSlp || c[7:3] == 5'h01));
        if (ok) begin
            if (c == 8'h03) eOsc = 1'b1;
            else if (c[5]) {eRom, eId, eGr} = c[2:0];
            else if (c[4] && !c[3]) begin
                eSw = c[2];
                if (c[2]) eBt = c[1:0];
                else eCt[4:3] = c[1:0];
            end
            // second half, steered by the held layout
            else if (c[4]) begin
                if (eSw) eBs = c[2:0];
                else eCt[2:0] = c[2:0];
            end
            else if (c[3]) begin
                eAmp = c[2];
                if (!eStb) eSlp = c[1];
                if (c[0] && !eStb) eOsc = 1'b0;
                eStb = c[0];
            end
            else if (c[2]) {eCms, eSgs} = c[1:0];
        end
        noteQ.push_back(expVec(ok));
        lpd_host_model_i.put(c);
    endtask

    // oldest note against every answer pulse
    always @(negedge core_clk) begin
        if (instrAccepted === 1'b1 || instrRejected === 1'b1) begin
            okSeen = instrAccepted;
            // run flags follow the settings one cycle later
            @(negedge core_clk);
            if (noteQ.size() == 0) check("stray answer", {okSeen, seenVec[34:0]}, 36'h0);
            else check("answer", {okSeen, seenVec[34:0]}, noteQ.pop_front());
        end
    end

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    initial begin
        repeat (10) @(negedge core_clk);
        reset = 1'b0;
        for (int i = 0; i < 8; i++) begin
            send(8'h20 | i[7:0]);
            if (i < 4) send(8'h04 | i[7:0]);
            if (i < 3) send(8'h14 | i[7:0]);
            if (i < 6) send(8'h18 | i[7:0]);
        end
        // random legal writes, back to back
        for (int i = 0; i < 16; i++) begin
            r = $random(seed);
            case (r[1:0])
                2'h0: send({6'h01, r[3:2]});
                2'h1: send({5'h04, r[4:2]});
                2'h2: send({6'h05, r[3] ? 2'h2 : {1'b0, r[2]}});
                default: send({5'h03, r[4] ? {2'h2, r[2]} : {1'b0, r[3:2]}});
            endcase
        end
        send(8'h13);
        send(8'h1d);
        // amplifier on, then off with single boost
        send(8'h0c);
        send(8'h14);
        send(8'h0a);
        send(8'h27);
        send(8'h07);
        send(8'h08);
        send(8'h09);
        keyscanIrqEnable = 1'b1;
        keyPressed = 1'b1;
        repeat (2) @(negedge core_clk);
        check("wake interrupt", {35'h0, keyscanIrq}, 36'h1);
        keyPressed = 1'b0;
        send(8'h22);
        send(8'h18);
        send(8'h03);
        send(8'h0d);
        send(8'h08);
        repeat (3) @(negedge core_clk);
        check("interrupt after wake", {35'h0, keyscanIrq}, 36'h0);
        send(8'h14);
        send(8'h1a);
        send(8'h25);
        // busy refuses everything
        clearBusy = 1'b1;
        send(8'h05);
        send(8'h0c);
        clearBusy = 1'b0;
        repeat (20) @(negedge core_clk);
        check("pending notes", 36'(noteQ.size()), 36'h0);
        print_verdict();
    end

    // watchdog, far beyond the expected run
    initial begin
        #50000;
        num_errors++;
        print_verdict();
    end
endmodule // testbench
